// File: ttylc_defines.vh
// constants for the teletype line controller
`ifndef TTYLC_DEFINES_VH
`define TTYLC_DEFINES_VH
`define TTYLC_CLK_HZ 100000000
`define TTYLC_TB_HZ 28160
// bit period 9.09 ms in microseconds
`define TTYLC_BIT_US 9090
// timebase ticks per bit: 28160 * 9090 / 1e6 = 255.97 -> 256 (nearest)
`define TTYLC_BIT_TICKS ((`TTYLC_TB_HZ * `TTYLC_BIT_US + 500000) / 1000000)
// hit guard 4.5 ms in microseconds, least time, rounded up in ticks
`define TTYLC_HIT_US 4500
`define TTYLC_HIT_TICKS ((`TTYLC_TB_HZ * `TTYLC_HIT_US + 999999) / 1000000)
`define TTYLC_FRAME_BITS 11
`define TTYLC_DATA_BITS 8
`define TTYLC_PORTS 4
`define TTYLC_BUF_RESET 8'h00
`endif

// File: ttylc_fifo.v
// hand-off queue module is kept in the line controller file, so all logic sits in one file

// File: ttylc_line_controller.v
// teletype line controller: buffer, serialiser, receiver and line register
`timescale 1ns/1ps
`include "ttylc_defines.vh"
module ttylc_line_controller #(
   parameter PORTS = `TTYLC_PORTS,
   parameter FIFO_DEPTH = 16
) (
   // clock and reset
   input wire mclk,
   input wire rst_n,
   // channel side load
   input wire lineBufferClear_n,
   input wire bufferTransferGate,
   input wire [7:0] channelBuffer,
   input wire transmitGo_n,
   input wire [PORTS-1:0] portEnableStatus,
   input wire goodParityMessage,
   // channel side reply
   output reg [7:0] lineRegister,
   output reg charReady_n,
   output reg demandInterrupt_n,
   output reg lineState_n,
   output reg [PORTS-1:0] portAlarmOut,
   // ports
   input wire bitTimebase,
   input wire [PORTS-1:0] portReceive,
   input wire [PORTS-1:0] portAlarm,
   output reg [PORTS-1:0] portTransmit
);
   localparam integer BIT_TICKS_I = `TTYLC_BIT_TICKS;
   localparam integer HIT_TICKS_I = `TTYLC_HIT_TICKS;
   localparam integer LAST_BIT_I = `TTYLC_FRAME_BITS - 1;
   localparam [8:0] BIT_TICKS = BIT_TICKS_I[8:0];
   localparam [8:0] HIT_TICKS = HIT_TICKS_I[8:0];
   localparam [8:0] HALF_TICKS = BIT_TICKS >> 1;
   localparam [3:0] LAST_BIT = LAST_BIT_I[3:0];
   localparam [1:0] ST_IDLE = 2'd0;
   localparam [1:0] ST_SEND = 2'd1;
   localparam [1:0] ST_HUNT = 2'd2;
   localparam [1:0] ST_RECV = 2'd3;

   // three-stage sync on every foreign input
   reg [2:0] tbSync_q;
   reg [PORTS-1:0] rxS1_q, rxS2_q, rxS3_q;
   reg [PORTS-1:0] alS1_q, alS2_q, alS3_q;
   reg tbLevel_q;
   reg [PORTS-1:0] rxLevel_q;
   always @(posedge mclk) begin
      if (!rst_n) begin
         tbSync_q <= 3'h0;
         rxS1_q <= {PORTS{1'b1}};
         rxS2_q <= {PORTS{1'b1}};
         rxS3_q <= {PORTS{1'b1}};
         alS1_q <= {PORTS{1'b0}};
         alS2_q <= {PORTS{1'b0}};
         alS3_q <= {PORTS{1'b0}};
         tbLevel_q <= 1'b0;
         rxLevel_q <= {PORTS{1'b1}};
      end else begin
         tbSync_q <= {tbSync_q[1:0], bitTimebase};
         rxS1_q <= portReceive;
         rxS2_q <= rxS1_q;
         rxS3_q <= rxS2_q;
         alS1_q <= portAlarm;
         alS2_q <= alS1_q;
         alS3_q <= alS2_q;
         if (tbSync_q[1] == tbSync_q[2]) begin
            tbLevel_q <= tbSync_q[2];
         end
         rxLevel_q <= (rxS2_q & rxS3_q) | (rxLevel_q & (rxS2_q ^ rxS3_q));
      end
   end
   wire tbSettled = (tbSync_q[1] == tbSync_q[2]);
   wire tick = tbSettled && tbSync_q[2] && !tbLevel_q;

   // go strobe edge, same domain
   reg goPrev_q;
   wire goFall = !transmitGo_n && goPrev_q;

   reg [1:0] state_q;
   reg [7:0] lineBuf_q;
   reg [8:0] tickCnt_q;
   reg [3:0] bitIdx_q;
   reg [1:0] rxPort_q;
   reg [PORTS-1:0] sendMask_q;
   reg txBit_q;
   reg handover_q;

   // hand-off of finished characters to the line register
   wire fifoInReady;
   wire fifoOutValid;
   wire [7:0] fifoOutData;
   wire frameDone = (state_q == ST_SEND || state_q == ST_RECV) && tick
      && tickCnt_q == BIT_TICKS - 1'b1 && bitIdx_q == LAST_BIT;
   wire fifoPop = fifoOutValid && charReady_n && !handover_q;

   ttylc_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH),
      .AW(4)
   ) charFifo (
      .mclk(mclk),
      .rst_n(rst_n),
      .inValid(frameDone),
      .inReady(fifoInReady),
      .inData(lineBuf_q),
      .outValid(fifoOutValid),
      .outReady(fifoPop),
      .outData(fifoOutData)
   );

   // lowest port showing space starts a hunt
   reg [1:0] spacePort;
   reg anySpace;
   integer i;
   always @* begin
      spacePort = 2'd0;
      anySpace = 1'b0;
      for (i = PORTS - 1; i >= 0; i = i - 1) begin
         if (!rxLevel_q[i]) begin
            spacePort = i[1:0];
            anySpace = 1'b1;
         end
      end
   end
   wire rxBit = rxLevel_q[rxPort_q];

   always @(posedge mclk) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         lineBuf_q <= `TTYLC_BUF_RESET;
         tickCnt_q <= 9'h000;
         bitIdx_q <= 4'h0;
         rxPort_q <= 2'd0;
         sendMask_q <= {PORTS{1'b0}};
         txBit_q <= 1'b1;
         goPrev_q <= 1'b1;
      end else begin
         goPrev_q <= transmitGo_n;
         case (state_q)
            ST_IDLE: begin
               txBit_q <= 1'b1;
               tickCnt_q <= 9'h000;
               bitIdx_q <= 4'h0;
               if (!lineBufferClear_n) begin
                  lineBuf_q <= `TTYLC_BUF_RESET;
               end else if (bufferTransferGate) begin
                  lineBuf_q <= channelBuffer;
               end
               // hold off hunts and ignore go strobes while the hand-off queue is full
               if (goFall && fifoInReady) begin
                  state_q <= ST_SEND;
                  sendMask_q <= portEnableStatus;
                  txBit_q <= 1'b0;
               end else if (anySpace && fifoInReady) begin
                  state_q <= ST_HUNT;
                  rxPort_q <= spacePort;
               end
            end
            ST_SEND: begin
               if (tick) begin
                  if (tickCnt_q == BIT_TICKS - 1'b1) begin
                     tickCnt_q <= 9'h000;
                     bitIdx_q <= bitIdx_q + 1'b1;
                     if (bitIdx_q == LAST_BIT) begin
                        state_q <= ST_IDLE;
                     end else if (bitIdx_q < `TTYLC_DATA_BITS) begin
                        txBit_q <= lineBuf_q[0];
                        lineBuf_q <= {lineBuf_q[0], lineBuf_q[7:1]};
                     end else begin
                        txBit_q <= 1'b1;
                     end
                  end else begin
                     tickCnt_q <= tickCnt_q + 1'b1;
                  end
               end
            end
            ST_HUNT: begin
               // start bit qualification against noise hits
               if (rxBit) begin
                  state_q <= ST_IDLE;
               end else if (tick) begin
                  if (tickCnt_q == HIT_TICKS) begin
                     state_q <= ST_RECV;
                     // now at middle of start bit; sample mid-bit from here
                     tickCnt_q <= HIT_TICKS + 1'b1;
                     bitIdx_q <= 4'h0;
                     sendMask_q <= portEnableStatus & ~({{(PORTS-1){1'b0}}, 1'b1} << rxPort_q);
                     txBit_q <= 1'b0;
                  end else begin
                     tickCnt_q <= tickCnt_q + 1'b1;
                  end
               end
            end
            default: begin
               if (tick) begin
                  if (tickCnt_q == BIT_TICKS - 1'b1) begin
                     tickCnt_q <= 9'h000;
                     bitIdx_q <= bitIdx_q + 1'b1;
                     if (bitIdx_q == LAST_BIT) begin
                        state_q <= ST_IDLE;
                     end
                  end else begin
                     tickCnt_q <= tickCnt_q + 1'b1;
                  end
                  // mid-bit sample, one per bit
                  if (tickCnt_q == HALF_TICKS) begin
                     if (bitIdx_q >= 4'd1 && bitIdx_q <= `TTYLC_DATA_BITS) begin
                        lineBuf_q <= {rxBit, lineBuf_q[7:1]};
                     end
                     txBit_q <= (bitIdx_q == 4'd0) ? 1'b0 : rxBit;
                  end
               end
            end
         endcase
      end
   end

   // outputs and line register
   always @(posedge mclk) begin
      if (!rst_n) begin
         lineRegister <= 8'h00;
         charReady_n <= 1'b1;
         demandInterrupt_n <= 1'b1;
         lineState_n <= 1'b1;
         portAlarmOut <= {PORTS{1'b0}};
         portTransmit <= {PORTS{1'b1}};
         handover_q <= 1'b0;
      end else begin
         // alarm level only moves once the last two sync stages agree
         portAlarmOut <= (alS3_q & alS2_q) | (portAlarmOut & (alS3_q ^ alS2_q));
         lineState_n <= (state_q == ST_IDLE) && !goFall;
         if (state_q == ST_SEND || state_q == ST_RECV) begin
            portTransmit <= ~sendMask_q | {PORTS{txBit_q}};
         end else begin
            portTransmit <= {PORTS{1'b1}};
         end
         if (fifoPop) begin
            lineRegister <= fifoOutData;
            charReady_n <= 1'b0;
         end else if (!charReady_n && goodParityMessage) begin
            charReady_n <= 1'b1;
            demandInterrupt_n <= 1'b0;
            handover_q <= 1'b1;
         end else begin
            demandInterrupt_n <= 1'b1;
            handover_q <= 1'b0;
         end
      end
   end
endmodule

// small synchronous fifo with valid/ready on both sides
module ttylc_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   // clock and reset
   input wire mclk,
   input wire rst_n,
   // fill side
   input wire inValid,
   output wire inReady,
   input wire [WIDTH-1:0] inData,
   // drain side
   output wire outValid,
   input wire outReady,
   output wire [WIDTH-1:0] outData
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wrPtr_q;
   reg [AW-1:0] rdPtr_q;
   reg [AW:0] count_q;
   wire doWr = inValid && inReady;
   wire doRd = outValid && outReady;
   assign inReady = (count_q != DEPTH[AW:0]);
   assign outValid = (count_q != {(AW+1){1'b0}});
   assign outData = mem[rdPtr_q];
   always @(posedge mclk) begin
      if (doWr) begin
         mem[wrPtr_q] <= inData;
      end
   end
   always @(posedge mclk) begin
      if (!rst_n) begin
         wrPtr_q <= {AW{1'b0}};
         rdPtr_q <= {AW{1'b0}};
         count_q <= {(AW+1){1'b0}};
      end else begin
         if (doWr) begin
            wrPtr_q <= (wrPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_q + 1'b1;
         end
         if (doRd) begin
            rdPtr_q <= (rdPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_q + 1'b1;
         end
         if (doWr && !doRd) begin
            count_q <= count_q + 1'b1;
         end else if (doRd && !doWr) begin
            count_q <= count_q - 1'b1;
         end
      end
   end
endmodule

// File: ttylc_lc_monitor.sv
// assertions on the line controller ports
`timescale 1ns/1ps
module ttylc_lc_monitor #(parameter PORTS = 4) (
   // clock and reset
   input wire mclk,
   input wire rst_n,
   // channel side
   input wire lineBufferClear_n,
   input wire bufferTransferGate,
   input wire [7:0] channelBuffer,
   input wire transmitGo_n,
   input wire [PORTS-1:0] portEnableStatus,
   input wire goodParityMessage,
   input wire [7:0] lineRegister,
   input wire charReady_n,
   input wire demandInterrupt_n,
   input wire lineState_n,
   input wire [PORTS-1:0] portAlarmOut,
   // ports
   input wire bitTimebase,
   input wire [PORTS-1:0] portReceive,
   input wire [PORTS-1:0] portAlarm,
   input wire [PORTS-1:0] portTransmit
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   go_busy_a: assert property ($fell(transmitGo_n) && lineState_n |=> !lineState_n)
      else $error("go not answered by busy");
   start_bit_a: assert property ($fell(transmitGo_n) && lineState_n |-> ##2
      portTransmit == ~portEnableStatus) else $error("start bit on wrong ports");
   idle_mark_a: assert property (lineState_n |-> &portTransmit)
      else $error("idle line not at mark");
   hand_over_a: assert property (goodParityMessage && !charReady_n |=>
      charReady_n && !demandInterrupt_n ##1 demandInterrupt_n) else $error("bad handover");
   irq_cause_a: assert property ($fell(demandInterrupt_n) |-> $past(goodParityMessage))
      else $error("demand without message");
   reg_hold_a: assert property (!charReady_n && $past(!charReady_n) |-> $stable(lineRegister))
      else $error("line register moved while ready");
   ready_hold_a: assert property (!charReady_n && !goodParityMessage |=> !charReady_n)
      else $error("ready dropped early");
   alarm_fwd_a: assert property ($changed(portAlarm) ##1 $stable(portAlarm)[*5] |->
      portAlarmOut == portAlarm) else $error("alarm not forwarded");
   cover property ($fell(charReady_n));
   cover property ($fell(demandInterrupt_n));
   cover property ($fell(lineState_n) && transmitGo_n);
endmodule
bind ttylc_line_controller ttylc_lc_monitor #(.PORTS(PORTS)) u_mon (
   .mclk(mclk), .rst_n(rst_n), .lineBufferClear_n(lineBufferClear_n),
   .bufferTransferGate(bufferTransferGate), .channelBuffer(channelBuffer),
   .transmitGo_n(transmitGo_n), .portEnableStatus(portEnableStatus),
   .goodParityMessage(goodParityMessage), .lineRegister(lineRegister),
   .charReady_n(charReady_n), .demandInterrupt_n(demandInterrupt_n),
   .lineState_n(lineState_n), .portAlarmOut(portAlarmOut), .bitTimebase(bitTimebase),
   .portReceive(portReceive), .portAlarm(portAlarm), .portTransmit(portTransmit));

// File: ttylc_term_model.sv
// terminal model: types characters and decodes one printing port
`timescale 1ns/1ps
module ttylc_term_model #(parameter BIT = 1024) (
   // clock
   input wire mclk,
   // printing side
   input wire [3:0] portTransmit,
   input wire [1:0] watchPort,
   output logic [9:0] rxFrame,
   output logic rxValid,
   // keyboard side
   output logic [3:0] portReceive
);
   integer i;
   initial begin
      portReceive = 4'hf;
      rxValid = 1'b0;
      rxFrame = 10'h000;
   end
   task sendChar(input logic [1:0] p, input logic [7:0] c);
      integer k;
      logic [10:0] f;
      f = {2'b11, c, 1'b0};
      for (k = 0; k < 11; k++) begin
         @(posedge mclk) portReceive[p] <= f[k];
         repeat (BIT - 1) @(posedge mclk);
      end
   endtask
   task hit(input logic [1:0] p, input integer len);
      @(posedge mclk) portReceive[p] <= 1'b0;
      repeat (len) @(posedge mclk);
      portReceive[p] <= 1'b1;
   endtask
   // samples mid-bit, so a drifting bit period shows as a wrong character
   initial forever begin
      @(posedge mclk);
      rxValid <= 1'b0;
      if (portTransmit[watchPort] === 1'b0) begin
         repeat (BIT / 2) @(posedge mclk);
         for (i = 0; i < 10; i++) begin
            repeat (BIT) @(posedge mclk);
            rxFrame <= {portTransmit[watchPort], rxFrame[9:1]};
         end
         rxValid <= 1'b1;
      end
   end
endmodule

// File: ttylc_line_controller_bench.sv
// self-checking bench for the line controller
`timescale 1ns/1ps
module ttylc_line_controller_bench;
   logic mclk = 0;
   logic rst_n = 0;
   logic lineBufferClear_n = 1;
   logic bufferTransferGate = 0;
   logic transmitGo_n = 1;
   logic goodParityMessage = 0;
   logic prevReady = 1;
   logic [7:0] channelBuffer = 8'h00;
   logic [7:0] ch;
   logic [3:0] portEnableStatus = 4'h0;
   logic [3:0] portAlarm = 4'h0;
   logic [3:0] tbCnt = 4'h0;
   wire [7:0] lineRegister;
   wire [9:0] rxFrame;
   wire [3:0] portAlarmOut, portReceive, portTransmit;
   wire charReady_n, demandInterrupt_n, lineState_n, rxValid;
   wire bitTimebase = tbCnt[1];
   logic [7:0] expQ[$];
   logic [7:0] wireQ[$];
   integer n_mismatch = 0;
   integer n_compared = 0;
   integer seed = 81156;
   ttylc_line_controller u_dut (.mclk(mclk), .rst_n(rst_n),
      .lineBufferClear_n(lineBufferClear_n), .bufferTransferGate(bufferTransferGate),
      .channelBuffer(channelBuffer), .transmitGo_n(transmitGo_n),
      .portEnableStatus(portEnableStatus), .goodParityMessage(goodParityMessage),
      .lineRegister(lineRegister), .charReady_n(charReady_n),
      .demandInterrupt_n(demandInterrupt_n), .lineState_n(lineState_n),
      .portAlarmOut(portAlarmOut), .bitTimebase(bitTimebase), .portReceive(portReceive),
      .portAlarm(portAlarm), .portTransmit(portTransmit));
   ttylc_term_model u_term (.mclk(mclk), .portTransmit(portTransmit), .watchPort(2'd0),
      .rxFrame(rxFrame), .rxValid(rxValid), .portReceive(portReceive));
   always #5 mclk = ~mclk;
   // timebase sped up to 4 clocks a tick, so a bit lasts 1024 clocks
   always @(posedge mclk) tbCnt <= tbCnt + 4'h1;
   task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
         n_mismatch++;
      end
   endtask
   task test_done;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task waitReady;
      integer i;
      i = 0;
      while ((charReady_n !== 1'b0 || lineState_n !== 1'b1) && i < 20000) begin
         @(posedge mclk);
         i++;
      end
      check("ready", {7'h0, charReady_n}, 8'h00);
   endtask
   task handOver;
      @(posedge mclk) goodParityMessage <= 1'b1;
      @(posedge mclk) goodParityMessage <= 1'b0;
      @(negedge mclk);
      check("handover", {6'h0, charReady_n, demandInterrupt_n}, 8'h02);
      @(negedge mclk);
      check("demand end", {7'h0, demandInterrupt_n}, 8'h01);
   endtask
   task load(input logic [7:0] c, input logic gate, input logic [3:0] en);
      @(posedge mclk) lineBufferClear_n <= 1'b0;
      portEnableStatus <= en;
      @(posedge mclk) lineBufferClear_n <= 1'b1;
      bufferTransferGate <= gate;
      channelBuffer <= c;
      @(posedge mclk) bufferTransferGate <= 1'b0;
   endtask
   task go(input logic [7:0] exp);
      expQ.push_back(exp);
      if (portEnableStatus[0])
         wireQ.push_back(exp);
      @(posedge mclk) transmitGo_n <= 1'b0;
      @(posedge mclk) transmitGo_n <= 1'b1;
      waitReady;
      handOver;
   endtask
   // result watcher: each result takes the oldest note
   always @(posedge mclk) begin
      prevReady <= charReady_n;
      if (rst_n && prevReady === 1'b1 && charReady_n === 1'b0)
         check("line reg", lineRegister, expQ.size() ? expQ.pop_front() : 8'hxx);
      if (rxValid === 1'b1) begin
         check("wire char", rxFrame[7:0], wireQ.size() ? wireQ.pop_front() : 8'hxx);
         check("stop bits", {6'h0, rxFrame[9:8]}, 8'h03);
      end
   end
   initial begin
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      check("reset reg", lineRegister, 8'h00);
      check("reset flags", {1'b0, charReady_n, demandInterrupt_n, lineState_n, portTransmit},
         8'h7f);
      check("reset alarm", {4'h0, portAlarmOut}, 8'h00);
      $display("reset test done");
      ch = 8'($random(seed));
      load(ch, 1'b1, 4'b0101);
      go(ch);
      $display("transmit test done");
      go(ch);
      $display("recirculate test done");
      load(8'($random(seed)), 1'b0, 4'($random(seed)));
      go(8'h00);
      $display("clear test done");
      @(posedge mclk) portEnableStatus <= 4'hf;
      ch = 8'($random(seed));
      expQ.push_back(ch);
      wireQ.push_back(ch);
      u_term.sendChar(2'd3, ch);
      waitReady;
      handOver;
      $display("receive test done");
      u_term.hit(2'd1, 300);
      repeat (2000) @(posedge mclk);
      @(negedge mclk);
      check("hit dropped", {6'h0, lineState_n, charReady_n}, 8'h03);
      $display("noise test done");
      @(posedge mclk) portAlarm <= 4'($random(seed)) | 4'h1;
      repeat (8) @(posedge mclk);
      @(negedge mclk);
      check("alarm", {4'h0, portAlarmOut}, {4'h0, portAlarm});
      check("pending", 8'(expQ.size() + wireQ.size()), 8'h00);
      $display("alarm test done");
      test_done;
   end
   initial begin
      repeat (90000) @(posedge mclk);
      n_mismatch++;
      test_done;
   end
endmodule
